// [rtl/xcvr_pkg.sv]
`default_nettype none
package xcvr_pkg;
  localparam int            NPORT          = 8;
  localparam int            PORT_W         = 3;
  localparam int            OFS_W          = 8;
  localparam int            ADDR_W         = 11;
  localparam int            DATA_W         = 8;
  // Device global register offsets, first framer space only
  localparam logic [7:0]    OFS_CTRL_ONE   = 8'hf0;
  localparam logic [7:0]    OFS_FRM_GLOBAL = 8'hf1;
  localparam logic [7:0]    OFS_CTRL_TWO   = 8'hf2;
  localparam logic [7:0]    OFS_CLK_SRC    = 8'hf3;
  localparam logic [7:0]    OFS_RSVD_A     = 8'hf4;
  localparam logic [7:0]    OFS_LU_RST     = 8'hf5;
  localparam logic [7:0]    OFS_FT_RST     = 8'hf6;
  localparam logic [7:0]    OFS_RSVD_B     = 8'hf7;
  localparam logic [7:0]    OFS_PART_ID    = 8'hf8;
  localparam logic [7:0]    OFS_FRM_SUM    = 8'hf9;
  localparam logic [7:0]    OFS_TST_SUM    = 8'hfa;
  localparam logic [7:0]    OFS_LU_SUM     = 8'hfb;
  localparam logic [7:0]    OFS_FRM_EN     = 8'hfc;
  localparam logic [7:0]    OFS_TST_EN     = 8'hfd;
  localparam logic [7:0]    OFS_LU_EN      = 8'hfe;
  localparam logic [7:0]    OFS_RSVD_HIGH  = 8'h1f;
  localparam logic [7:0]    OFS_GLOBAL_LO  = 8'hf0;
  localparam logic [7:0]    OFS_GLOBAL_HI  = 8'hfe;
  // Control-one field positions
  localparam int            BIT_LOSS_SEL   = 5;
  localparam int            BIT_WIRE_OR    = 4;
  localparam int            BIT_BCAST      = 2;
  localparam int            BIT_LATCH      = 1;
  localparam int            BIT_INHIBIT    = 0;
  localparam logic [7:0]    CTRL_ONE_USED  = 8'h37;
  localparam logic [7:0]    RESET_BYTE     = 8'h00;
  // Arbitrary identity value, names no real part
  localparam logic [7:0]    PART_ID_VALUE  = 8'h5a;
  // Controller register offsets
  localparam logic [3:0]    HOFS_TGT_OFS   = 4'h0;
  localparam logic [3:0]    HOFS_TGT_PORT  = 4'h1;
  localparam logic [3:0]    HOFS_WDATA     = 4'h2;
  localparam logic [3:0]    HOFS_CMD       = 4'h3;
  localparam logic [3:0]    HOFS_RDATA     = 4'h4;
  localparam logic [3:0]    HOFS_STATUS    = 4'h5;
  localparam logic [3:0]    HOFS_MASK      = 4'h6;
  localparam int            CMD_WRITE      = 0;
  localparam int            CMD_READ       = 1;
  localparam int            ST_DONE        = 0;
  localparam int            ST_REFUSED     = 1;
  localparam int            ST_DEV_IRQ     = 2;
  localparam logic [2:0]    ST_USED        = 3'h7;

  function automatic logic is_global_ofs(input logic [7:0] ofs);
    is_global_ofs = ((ofs >= OFS_GLOBAL_LO) && (ofs <= OFS_GLOBAL_HI)) || (ofs == OFS_RSVD_HIGH);
  endfunction : is_global_ofs

  function automatic logic is_reserved_ofs(input logic [7:0] ofs);
    is_reserved_ofs = (ofs == OFS_RSVD_A) || (ofs == OFS_RSVD_B) || (ofs == OFS_RSVD_HIGH);
  endfunction : is_reserved_ofs
endpackage : xcvr_pkg
`default_nettype wire

// [rtl/xcvr_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface xcvr_if;
  logic        wr;
  logic        rd;
  logic [10:0] addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        int_n;
  modport dev  (input wr, rd, addr, wdata, output rdata, int_n);
  modport host (output wr, rd, addr, wdata, input rdata, int_n);
endinterface : xcvr_if
`default_nettype wire

// [rtl/global_regs_dev.sv]
// Notes on behaviour
// R1: Loss pin shows frame or clock loss
// R2: Bit four picks internal mux or wire-OR
// R3: Host should keep wire-OR bit at zero; the host passes bit four through unchanged
// R4: Broadcast bit copies port writes to all
// R5: Host clears broadcast before any read
// R6: Trigger rising edge latches enabled framer counters
// R7: Only rising edge latches; clear then set
// R8: Host writes zeros to reserved locations
// R9: Globals only in first framer space
// R10: Host zeroes shadow globals in other spaces
// R11: Three interrupt summaries are read-only
// R12: Three interrupt enables are read-write
// R13: Separate line and framer/tester reset registers
// R14: Read-only identification register
// R15: Inhibit bit clear lets interrupt pin drive
// R16: Edge detected in clock domain, one pulse
`timescale 1ns/100ps
`default_nettype none
module global_regs_dev (
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  xcvr_if.dev             bus,
  output logic [7:0]      o_unit_wr,
  output logic [7:0]      o_unit_rd,
  output logic [7:0]      o_unit_ofs,
  output logic [7:0]      o_unit_wdata,
  input  wire logic [7:0] i_unit_rdata,
  input  wire logic [7:0] i_latch_accept,
  output logic [7:0]      o_latch_pulse,
  input  wire logic [7:0] i_framer_irq,
  input  wire logic [7:0] i_tester_irq,
  input  wire logic [7:0] i_line_unit_irq,
  output logic            o_loss_pin_function_select,
  output logic            o_external_wire_or_select,
  output logic            o_broadcast_write_enable,
  output logic [7:0]      o_framer_global_control,
  output logic [7:0]      o_transceiver_control_two,
  output logic [7:0]      o_clock_source_control,
  output logic [7:0]      o_line_unit_soft_reset,
  output logic [7:0]      o_framer_tester_soft_reset
);

  logic [2:0] acc_port;
  logic [7:0] acc_ofs;
  logic       global_hit;
  logic       unit_hit;
  logic [7:0] port_onehot;
  logic [7:0] transceiver_control_one;
  logic [7:0] framer_global_control;
  logic [7:0] transceiver_control_two;
  logic [7:0] clock_source_control;
  logic [7:0] line_unit_soft_reset;
  logic [7:0] framer_tester_soft_reset;
  logic [7:0] framer_irq_enable;
  logic [7:0] tester_irq_enable;
  logic [7:0] line_unit_irq_enable;
  logic       latch_prev;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic       int_n;
  logic       irq_any;
  logic       gwr;

  assign acc_port    = bus.addr[10:8];
  assign acc_ofs     = bus.addr[7:0];
  // Shadow copies in ports 1..7 decode as global but hit nothing
  assign global_hit  = (acc_port == 3'h0) && xcvr_pkg::is_global_ofs(acc_ofs); // R9
  assign unit_hit    = !xcvr_pkg::is_global_ofs(acc_ofs);
  assign port_onehot = 8'h01 << acc_port;
  assign gwr         = bus.wr && global_hit;

  // Unit strobes are combinational so a unit read answers in step with the bus
  always_comb begin
    o_unit_wr = 8'h00;
    o_unit_rd = 8'h00;
    if (bus.wr && unit_hit) begin
      if (transceiver_control_one[xcvr_pkg::BIT_BCAST]) begin
        o_unit_wr = 8'hff; // R4
      end else begin
        o_unit_wr = port_onehot;
      end
    end
    if (bus.rd && unit_hit) begin
      o_unit_rd = port_onehot;
    end
  end

  assign o_unit_ofs   = acc_ofs;
  assign o_unit_wdata = bus.wdata;

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      transceiver_control_one <= xcvr_pkg::RESET_BYTE;
    end else if (gwr && (acc_ofs == xcvr_pkg::OFS_CTRL_ONE)) begin
      // Unused bits never store so they always read as zero
      transceiver_control_one <= bus.wdata & xcvr_pkg::CTRL_ONE_USED;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      framer_global_control   <= xcvr_pkg::RESET_BYTE;
      transceiver_control_two <= xcvr_pkg::RESET_BYTE;
      clock_source_control    <= xcvr_pkg::RESET_BYTE;
    end else if (gwr) begin
      if (acc_ofs == xcvr_pkg::OFS_FRM_GLOBAL) begin
        framer_global_control <= bus.wdata;
      end
      if (acc_ofs == xcvr_pkg::OFS_CTRL_TWO) begin
        transceiver_control_two <= bus.wdata;
      end
      if (acc_ofs == xcvr_pkg::OFS_CLK_SRC) begin
        clock_source_control <= bus.wdata;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      line_unit_soft_reset     <= xcvr_pkg::RESET_BYTE;
      framer_tester_soft_reset <= xcvr_pkg::RESET_BYTE;
    end else if (gwr) begin
      if (acc_ofs == xcvr_pkg::OFS_LU_RST) begin
        line_unit_soft_reset <= bus.wdata; // R13
      end
      if (acc_ofs == xcvr_pkg::OFS_FT_RST) begin
        framer_tester_soft_reset <= bus.wdata; // R13
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      framer_irq_enable    <= xcvr_pkg::RESET_BYTE;
      tester_irq_enable    <= xcvr_pkg::RESET_BYTE;
      line_unit_irq_enable <= xcvr_pkg::RESET_BYTE;
    end else if (gwr) begin
      if (acc_ofs == xcvr_pkg::OFS_FRM_EN) begin
        framer_irq_enable <= bus.wdata; // R12
      end
      if (acc_ofs == xcvr_pkg::OFS_TST_EN) begin
        tester_irq_enable <= bus.wdata; // R12
      end
      if (acc_ofs == xcvr_pkg::OFS_LU_EN) begin
        line_unit_irq_enable <= bus.wdata; // R12
      end
    end
  end

  // Counter latch: only a fresh rising edge fires, a held one stays quiet
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      latch_prev    <= 1'b0;
      o_latch_pulse <= 8'h00;
    end else begin
      latch_prev <= transceiver_control_one[xcvr_pkg::BIT_LATCH]; // R16
      if (transceiver_control_one[xcvr_pkg::BIT_LATCH] && !latch_prev) begin
        o_latch_pulse <= i_latch_accept; // R6 R7
      end else begin
        o_latch_pulse <= 8'h00;
      end
    end
  end

  // Reads of summaries show live unit state; writes to them are dropped
  always_comb begin
    next_rdata = 8'h00;
    if (bus.rd && unit_hit) begin
      next_rdata = i_unit_rdata;
    end else if (bus.rd && global_hit) begin
      unique case (acc_ofs)
        xcvr_pkg::OFS_CTRL_ONE:   next_rdata = transceiver_control_one;
        xcvr_pkg::OFS_FRM_GLOBAL: next_rdata = framer_global_control;
        xcvr_pkg::OFS_CTRL_TWO:   next_rdata = transceiver_control_two;
        xcvr_pkg::OFS_CLK_SRC:    next_rdata = clock_source_control;
        xcvr_pkg::OFS_LU_RST:     next_rdata = line_unit_soft_reset;
        xcvr_pkg::OFS_FT_RST:     next_rdata = framer_tester_soft_reset;
        xcvr_pkg::OFS_PART_ID:    next_rdata = xcvr_pkg::PART_ID_VALUE; // R14
        xcvr_pkg::OFS_FRM_SUM:    next_rdata = i_framer_irq; // R11
        xcvr_pkg::OFS_TST_SUM:    next_rdata = i_tester_irq; // R11
        xcvr_pkg::OFS_LU_SUM:     next_rdata = i_line_unit_irq; // R11
        xcvr_pkg::OFS_FRM_EN:     next_rdata = framer_irq_enable;
        xcvr_pkg::OFS_TST_EN:     next_rdata = tester_irq_enable;
        xcvr_pkg::OFS_LU_EN:      next_rdata = line_unit_irq_enable;
        default:                  next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end

  assign irq_any = |((i_framer_irq & framer_irq_enable)
                   | (i_tester_irq & tester_irq_enable)
                   | (i_line_unit_irq & line_unit_irq_enable));

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      int_n <= 1'b1;
    end else begin
      int_n <= !(irq_any && !transceiver_control_one[xcvr_pkg::BIT_INHIBIT]); // R15
    end
  end

  assign bus.rdata = rdata;
  assign bus.int_n = int_n;

  // Pin function selects go straight to the port pin muxes
  assign o_loss_pin_function_select = transceiver_control_one[xcvr_pkg::BIT_LOSS_SEL]; // R1
  assign o_external_wire_or_select  = transceiver_control_one[xcvr_pkg::BIT_WIRE_OR]; // R2
  assign o_broadcast_write_enable   = transceiver_control_one[xcvr_pkg::BIT_BCAST];
  assign o_framer_global_control    = framer_global_control;
  assign o_transceiver_control_two  = transceiver_control_two;
  assign o_clock_source_control     = clock_source_control;
  assign o_line_unit_soft_reset     = line_unit_soft_reset;
  assign o_framer_tester_soft_reset = framer_tester_soft_reset;

endmodule : global_regs_dev
`default_nettype wire

// [rtl/global_regs_host.sv]
`timescale 1ns/100ps
`default_nettype none
module global_regs_host (
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  xcvr_if.host            bus,
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic [7:0]      o_rdata,
  output logic            o_irq
);

  typedef enum logic [3:0] {
    S_IDLE  = 4'b0001,
    S_WRITE = 4'b0010,
    S_READ  = 4'b0100,
    S_CAPT  = 4'b1000
  } state_e;

  state_e     state;
  logic [7:0] tgt_ofs;
  logic [2:0] tgt_port;
  logic [7:0] tgt_wdata;
  logic [7:0] read_result;
  logic [2:0] status;
  logic [2:0] mask;
  logic       bcast_shadow;
  logic       cmd_wr;
  logic       go_write;
  logic       go_read;
  logic       refuse;
  logic       done_evt;
  logic       tgt_zero;
  logic       tgt_ctrl_one;
  logic [2:0] set_bits;
  logic [2:0] clr_bits;
  logic [7:0] next_rdata;

  assign cmd_wr   = i_wr && (i_addr == xcvr_pkg::HOFS_CMD);
  // Reads while broadcast is on would return one port only, so refuse them
  assign refuse   = cmd_wr && ((state != S_IDLE)
                  || (i_wdata[xcvr_pkg::CMD_READ] && bcast_shadow)); // R5
  assign go_write = cmd_wr && !refuse && i_wdata[xcvr_pkg::CMD_WRITE];
  assign go_read  = cmd_wr && !refuse && !i_wdata[xcvr_pkg::CMD_WRITE]
                  && i_wdata[xcvr_pkg::CMD_READ];
  assign done_evt = (state == S_WRITE) || (state == S_CAPT);
  // Reserved spots and shadow globals in ports 1..7 only ever get zeros
  assign tgt_zero = xcvr_pkg::is_reserved_ofs(tgt_ofs)
                  || ((tgt_port != 3'h0) && xcvr_pkg::is_global_ofs(tgt_ofs)); // R8 R10
  assign tgt_ctrl_one = (tgt_port == 3'h0) && (tgt_ofs == xcvr_pkg::OFS_CTRL_ONE);

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      state <= S_IDLE;
    end else begin
      unique case (state)
        S_IDLE: begin
          if (go_write) begin
            state <= S_WRITE;
          end else if (go_read) begin
            state <= S_READ;
          end
        end
        S_WRITE: state <= S_IDLE;
        S_READ:  state <= S_CAPT;
        S_CAPT:  state <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      tgt_ofs   <= 8'h00;
      tgt_port  <= 3'h0;
      tgt_wdata <= 8'h00;
      mask      <= 3'h0;
    end else if (i_wr) begin
      if (i_addr == xcvr_pkg::HOFS_TGT_OFS) begin
        tgt_ofs <= i_wdata;
      end
      if (i_addr == xcvr_pkg::HOFS_TGT_PORT) begin
        tgt_port <= i_wdata[2:0];
      end
      if (i_addr == xcvr_pkg::HOFS_WDATA) begin
        tgt_wdata <= i_wdata;
      end
      if (i_addr == xcvr_pkg::HOFS_MASK) begin
        mask <= i_wdata[2:0];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      bcast_shadow <= 1'b0;
    end else if ((state == S_WRITE) && tgt_ctrl_one) begin
      bcast_shadow <= tgt_wdata[xcvr_pkg::BIT_BCAST];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      read_result <= 8'h00;
    end else if (state == S_CAPT) begin
      read_result <= bus.rdata;
    end
  end

  // Sticky status: a set in the clearing cycle wins
  assign set_bits = {!bus.int_n, refuse, done_evt};
  assign clr_bits = (i_wr && (i_addr == xcvr_pkg::HOFS_STATUS)) ? i_wdata[2:0] : 3'h0;

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      status <= 3'h0;
    end else begin
      status <= (status & ~clr_bits) | set_bits;
    end
  end

  assign o_irq = |(status & mask);

  // Interface strobes are combinational from the one-cycle states
  assign bus.wr    = (state == S_WRITE);
  assign bus.rd    = (state == S_READ);
  assign bus.addr  = {tgt_port, tgt_ofs};
  assign bus.wdata = tgt_zero ? 8'h00
                   : (tgt_ctrl_one ? (tgt_wdata & xcvr_pkg::CTRL_ONE_USED) : tgt_wdata); // R8

  always_comb begin
    next_rdata = 8'h00;
    if (i_rd) begin
      unique case (i_addr)
        xcvr_pkg::HOFS_TGT_OFS:  next_rdata = tgt_ofs;
        xcvr_pkg::HOFS_TGT_PORT: next_rdata = {5'h00, tgt_port};
        xcvr_pkg::HOFS_WDATA:    next_rdata = tgt_wdata;
        xcvr_pkg::HOFS_CMD:      next_rdata = {7'h00, (state != S_IDLE)};
        xcvr_pkg::HOFS_RDATA:    next_rdata = read_result;
        xcvr_pkg::HOFS_STATUS:   next_rdata = {5'h00, status};
        xcvr_pkg::HOFS_MASK:     next_rdata = {5'h00, mask};
        default:                 next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= next_rdata;
    end
  end

endmodule : global_regs_host
`default_nettype wire

// [tb/global_regs_props.sv]
`timescale 1ns/100ps
`default_nettype none
module global_regs_props (
  input wire logic        i_clk,
  input wire logic        i_rstn,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [10:0] addr,
  input wire logic [7:0]  wdata,
  input wire logic [7:0]  rdata,
  input wire logic        int_n
);
  logic [7:0] ctrl;
  logic       rsvd;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);
  // Control one as last written on the wire; the device must agree with it
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      ctrl <= 8'h00;
    end else if (wr && addr == 11'h0f0) begin
      ctrl <= wdata;
    end
  end
  // Globals seen through ports 1 to 7 are shadows and count as reserved
  assign rsvd = addr[7:0] == 8'hf4 || addr[7:0] == 8'hf7 || addr[7:0] == 8'h1f ||
                (addr[10:8] != 3'h0 && addr[7:0] >= 8'hf0 && addr[7:0] != 8'hff);
  a_strobes_apart: assert property (!(wr && rd))
    else $error("write and read strobes together");
  a_write_one_cycle: assert property (wr |=> !wr)
    else $error("write strobe longer than one cycle");
  a_rdata_idle_zero: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data not zero outside read answer");
  a_rsvd_read_zero: assert property (rd && rsvd |=> rdata == 8'h00)
    else $error("reserved location read not zero");
  a_rsvd_write_zero: assert property (wr && rsvd |-> wdata == 8'h00)
    else $error("reserved location written with nonzero data");
  a_ident_read: assert property (rd && addr == 11'h0f8 |=> rdata == xcvr_pkg::PART_ID_VALUE)
    else $error("identity read wrong");
  a_ctrl_readback: assert property (
    rd && addr == 11'h0f0 |=> rdata == (ctrl & 8'h37))
    else $error("control one read differs from last write");
  a_ctrl_unused_zero: assert property (wr && addr == 11'h0f0 |-> (wdata & 8'hc8) == 8'h00)
    else $error("unused control one bits written high");
  a_read_no_bcast: assert property (rd |-> !ctrl[2])
    else $error("read issued while broadcast set");
  a_inhibit_holds: assert property (ctrl[0] && $past(ctrl[0]) |-> int_n)
    else $error("interrupt pin low while inhibited");
endmodule : global_regs_props
`default_nettype wire

// [tb/octal_transceiver_global_regs_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module octal_transceiver_global_regs_tb_top;
  localparam logic [7:0] OFS_LIST [15] = '{8'hf1, 8'hf2, 8'hf3, 8'hf4, 8'hf5, 8'hf6, 8'hf7,
    8'hf8, 8'hf9, 8'hfa, 8'hfb, 8'hfc, 8'hfd, 8'hfe, 8'h1f};
  logic       i_clk = 1'b0, i_rstn = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0;
  logic [3:0] sw_addr = 4'h0;
  logic [7:0] sw_wdata = 8'h00, unit_rdata = 8'h00, accept = 8'h00;
  logic [7:0] f_irq = 8'h00, t_irq = 8'h00, l_irq = 8'h00;
  logic       irq, loss_sel, wor_sel, bcast;
  logic [7:0] sw_rdata, unit_wr, unit_rd, unit_ofs, unit_wdata, pulse, seen_wr, seen_pulse;
  logic [7:0] seen_rd, seen_ofs, seen_wdata;
  logic [7:0] gfc, ctl2, clk_src, lu_rst, ft_rst;
  logic [7:0] wv [15];
  int         fails = 0, cmp_count = 0, npulse = 0, seed = 32'h254817dc;
  xcvr_if i_if ();
  global_regs_host i_global_regs_host (.i_clk(i_clk), .i_rstn(i_rstn), .bus(i_if.host),
    .i_addr(sw_addr), .i_wdata(sw_wdata), .i_wr(wr_stb), .i_rd(rd_stb), .o_rdata(sw_rdata),
    .o_irq(irq));
  global_regs_dev i_global_regs_dev (.i_clk(i_clk), .i_rstn(i_rstn), .bus(i_if.dev),
    .o_unit_wr(unit_wr), .o_unit_rd(unit_rd), .o_unit_ofs(unit_ofs),
    .o_unit_wdata(unit_wdata), .i_unit_rdata(unit_rdata), .i_latch_accept(accept),
    .o_latch_pulse(pulse), .i_framer_irq(f_irq), .i_tester_irq(t_irq),
    .i_line_unit_irq(l_irq), .o_loss_pin_function_select(loss_sel),
    .o_external_wire_or_select(wor_sel), .o_broadcast_write_enable(bcast),
    .o_framer_global_control(gfc), .o_transceiver_control_two(ctl2),
    .o_clock_source_control(clk_src), .o_line_unit_soft_reset(lu_rst),
    .o_framer_tester_soft_reset(ft_rst));
  global_regs_props i_global_regs_props (.i_clk(i_clk), .i_rstn(i_rstn), .wr(i_if.wr),
    .rd(i_if.rd), .addr(i_if.addr), .wdata(i_if.wdata), .rdata(i_if.rdata),
    .int_n(i_if.int_n));

  initial begin
    forever #2.5 i_clk = ~i_clk;
  end

  // Counting pulse cycles makes a stretched latch pulse show as an extra latch
  always @(posedge i_clk) begin
    if (|unit_wr) begin
      seen_wr <= unit_wr;
      seen_ofs <= unit_ofs;
      seen_wdata <= unit_wdata;
    end
    if (|unit_rd) begin
      seen_rd <= unit_rd;
    end
    if (|pulse) begin
      npulse <= npulse + 1;
      seen_pulse <= pulse;
    end
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  function automatic logic [7:0] exp_rd(input logic [7:0] ofs, input logic [7:0] d);
    case (ofs)
      8'hf4, 8'hf7, 8'h1f: exp_rd = 8'h00;
      8'hf8: exp_rd = xcvr_pkg::PART_ID_VALUE;
      8'hf9: exp_rd = f_irq;
      8'hfa: exp_rd = t_irq;
      8'hfb: exp_rd = l_irq;
      default: exp_rd = d;
    endcase
  endfunction : exp_rd

  task automatic sw_wr(input logic [3:0] a, input logic [7:0] d);
    sw_addr <= a;
    sw_wdata <= d;
    wr_stb <= 1'b1;
    @(posedge i_clk);
    wr_stb <= 1'b0;
    @(posedge i_clk);
  endtask : sw_wr

  task automatic sw_rd(input logic [3:0] a, output logic [7:0] d);
    sw_addr <= a;
    rd_stb <= 1'b1;
    @(posedge i_clk);
    rd_stb <= 1'b0;
    #1 d = sw_rdata;
    @(posedge i_clk);
  endtask : sw_rd

  task automatic dev_op(input logic [2:0] p, input logic [7:0] ofs, d, cmd,
                        output logic [7:0] st, output logic [7:0] q);
    int n;
    sw_wr(4'h0, ofs);
    sw_wr(4'h1, {5'h00, p});
    sw_wr(4'h2, d);
    sw_wr(4'h3, cmd);
    n = 0;
    st = 8'h00;
    while (st[1:0] == 2'b00 && n < 20) begin
      sw_rd(4'h5, st);
      n++;
    end
    chk("command finish", 8'h01, {7'h00, n < 20});
    sw_rd(4'h4, q);
    sw_wr(4'h5, 8'h03);
  endtask : dev_op

  task automatic wr_dev(input logic [2:0] p, input logic [7:0] ofs, d);
    logic [7:0] st, q;
    dev_op(p, ofs, d, 8'h01, st, q);
  endtask : wr_dev

  task automatic rd_dev(input logic [2:0] p, input logic [7:0] ofs, output logic [7:0] q);
    logic [7:0] st;
    dev_op(p, ofs, 8'h00, 8'h02, st, q);
  endtask : rd_dev

  initial begin
    #100000;
    fails++;
    stop_test();
  end

  initial begin
    logic [7:0] q, s, o;
    logic [2:0] p;
    int         n0;
    repeat (3) @(posedge i_clk);
    i_rstn <= 1'b1;
    f_irq <= 8'($random(seed)) | 8'h01;
    t_irq <= 8'($random(seed)) | 8'h02;
    l_irq <= 8'($random(seed)) | 8'h80;
    unit_rdata <= 8'($random(seed));
    accept <= 8'($random(seed)) | 8'h01;
    sw_rd(4'h9, q);
    chk("unmapped", 8'h00, q);
    rd_dev(3'h0, 8'hf0, q);
    chk("control reset", 8'h00, q);
    for (int k = 0; k < 15; k++) begin
      o = OFS_LIST[k];
      rd_dev(3'h0, o, q);
      chk("reset value", exp_rd(o, 8'h00), q);
      wv[k] = 8'($random(seed));
      wr_dev(3'h0, o, wv[k]);
      rd_dev(3'h0, o, q);
      chk("readback", exp_rd(o, wv[k]), q);
      p = 3'(1 + ({$random(seed)} % 7));
      wr_dev(p, o, ~wv[k]);
      rd_dev(p, o, q);
      chk("shadow read", 8'h00, q);
      rd_dev(3'h0, o, q);
      chk("after shadow", exp_rd(o, wv[k]), q);
    end
    chk("framer global", wv[0], gfc);
    chk("control two", wv[1], ctl2);
    chk("clock source", wv[2], clk_src);
    chk("line reset", wv[4], lu_rst);
    chk("framer reset", wv[5], ft_rst);
    // A command with both bits set performs the write
    dev_op(3'h0, 8'hf2, 8'h69, 8'h03, s, q);
    rd_dev(3'h0, 8'hf2, q);
    chk("both bits", 8'h69, q);
    // A command landing while a read is still capturing must be refused
    sw_wr(4'h5, 8'h07);
    sw_wr(4'h3, 8'h02);
    sw_wr(4'h3, 8'h01);
    sw_rd(4'h5, s);
    chk("busy refused", 8'h03, s & 8'h03);
    sw_wr(4'h5, 8'h07);
    // Unused bits are offered too; the host must strip them
    wr_dev(3'h0, 8'hf0, 8'hf8);
    rd_dev(3'h0, 8'hf0, q);
    chk("control one", 8'h30, q);
    chk("loss select", 8'h01, {7'h00, loss_sel});
    chk("wire or", 8'h01, {7'h00, wor_sel});
    wr_dev(3'h0, 8'hf0, 8'h00);
    chk("loss select", 8'h00, {7'h00, loss_sel});
    chk("wire or", 8'h00, {7'h00, wor_sel});
    wr_dev(3'h0, 8'hf0, 8'h04);
    chk("broadcast", 8'h01, {7'h00, bcast});
    wr_dev(3'h5, 8'h10, 8'h3c);
    chk("broadcast strobes", 8'hff, seen_wr);
    chk("unit offset", 8'h10, seen_ofs);
    chk("unit data", 8'h3c, seen_wdata);
    dev_op(3'h0, 8'hf1, 8'h00, 8'h02, s, q);
    chk("read refused", 8'h02, s & 8'h02);
    wr_dev(3'h0, 8'hf0, 8'h00);
    wr_dev(3'h5, 8'h10, 8'h3c);
    chk("port strobe", 8'h20, seen_wr);
    rd_dev(3'h2, 8'h30, q);
    chk("unit read", unit_rdata, q);
    chk("unit read strobe", 8'h04, seen_rd);
    n0 = npulse;
    wr_dev(3'h0, 8'hf0, 8'h02);
    chk("latch count", 8'h01, 8'(npulse - n0));
    chk("latch ports", accept, seen_pulse);
    wr_dev(3'h0, 8'hf0, 8'h02);
    chk("latch held", 8'h01, 8'(npulse - n0));
    wr_dev(3'h0, 8'hf0, 8'h00);
    wr_dev(3'h0, 8'hf0, 8'h02);
    chk("latch again", 8'h02, 8'(npulse - n0));
    wr_dev(3'h0, 8'hf0, 8'h00);
    for (int i = 0; i < 3; i++) begin
      wr_dev(3'h0, 8'hfc + 8'(i), 8'h00);
    end
    for (int i = 0; i < 3; i++) begin
      sw_wr(4'h5, 8'h07);
      wr_dev(3'h0, 8'hfc + 8'(i), 8'hff);
      sw_wr(4'h6, 8'h04);
      #1;
      chk("pin active", 8'h00, {7'h00, i_if.int_n});
      chk("irq raised", 8'h01, {7'h00, irq});
      @(posedge i_clk);
      sw_wr(4'h6, 8'h00);
      #1;
      chk("irq masked", 8'h00, {7'h00, irq});
      @(posedge i_clk);
      wr_dev(3'h0, 8'hf0, 8'h01);
      sw_wr(4'h5, 8'h04);
      sw_wr(4'h6, 8'h04);
      #1;
      chk("pin inhibited", 8'h01, {7'h00, i_if.int_n});
      chk("irq cleared", 8'h00, {7'h00, irq});
      @(posedge i_clk);
      wr_dev(3'h0, 8'hf0, 8'h00);
      wr_dev(3'h0, 8'hfc + 8'(i), 8'h00);
      sw_wr(4'h6, 8'h00);
      #1;
      chk("pin quiet", 8'h01, {7'h00, i_if.int_n});
      @(posedge i_clk);
    end
    stop_test();
  end
endmodule : octal_transceiver_global_regs_tb_top
`default_nettype wire
